// file: hdl/flash_seq_host.v
// host-side command sequencer for a parallel NOR flash, controlled over APB
// Functional notes
// - enter secured region with three writes; leave it with four writes.
// - normal program is two unlocks, program set-up, then address with data.
// - unlock bypass entry is two unlocks then command 20h.
// - bypass program is A0h then address and data, repeatable.
// - leave bypass with writes of 90h then 00h; device returns to read.
// - chip erase is two unlocks, set-up, two unlocks, chip erase command.
// - sector erase is two unlocks, set-up, two unlocks, sector address with 30h.
// - host spaces added sector erase writes less than 50 us apart.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "flash_seq_defines.vh"

module flash_seq_host #(
  parameter [15:0] WINDOW_CYC = `ERASE_WINDOW_CYC
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // flash pins
  output wire [21:0] flash_addr,
  output wire [15:0] flash_dq_out,
  output wire flash_dq_oe,
  input wire [15:0] flash_dq_in,
  output wire flash_ce_n,
  output wire flash_we_n,
  output wire flash_oe_n,
  output reg flash_byte_n,
  output reg flash_reset_n,
  output reg accel_high_voltage,
  input wire ready_busy_n
);
  localparam S_IDLE = 3'h0;
  localparam S_ISSUE = 3'h1;
  localparam S_WAIT = 3'h2;
  localparam S_SETTLE = 3'h3;
  localparam S_POLL = 3'h4;
  localparam S_WINDOW = 3'h5;
  localparam A_UNLOCK1 = 2'h0;
  localparam A_UNLOCK2 = 2'h1;
  localparam A_USER = 2'h2;
  localparam A_NONE = 2'h3;

  reg [2:0] state;
  reg [3:0] op;
  reg [2:0] step;
  reg [15:0] cnt;
  reg cyc_start;
  reg [2:0] cfg;
  reg [21:0] user_addr;
  reg [15:0] user_data;
  reg [15:0] read_data;
  reg done_flag;
  reg error_flag;
  reg bypass;
  reg secured;
  reg rb1;
  reg rb2;
  reg rb3;
  reg rb_stable;
  wire cyc_done;
  wire [15:0] cyc_rdata;
  wire [10:0] entry;
  wire [21:0] entry_addr;
  wire [15:0] entry_data;

  // number of bus cycles in each operation
  function [2:0] seq_len;
    input [3:0] code;
    begin
      case (code)
        `OP_READ: seq_len = 3'h1;
        `OP_RESET: seq_len = 3'h1;
        `OP_PROGRAM: seq_len = 3'h4;
        `OP_CHIP_ERASE: seq_len = 3'h6;
        `OP_SECTOR_ERASE: seq_len = 3'h6;
        `OP_ADD_SECTOR: seq_len = 3'h1;
        `OP_ENTER_SECURED: seq_len = 3'h3;
        `OP_EXIT_SECURED: seq_len = 3'h4;
        `OP_BYPASS_ENTER: seq_len = 3'h3;
        default: seq_len = 3'h2;
      endcase
    end
  endfunction

  // one cycle of an operation: {use user data, address select, command byte}
  function [10:0] seq_entry;
    input [3:0] code;
    input [2:0] idx;
    begin
      seq_entry = {1'b0, A_NONE, `FL_RESET};
      case (code)
        `OP_READ: seq_entry = {1'b0, A_USER, `FL_ZERO};
        `OP_RESET: seq_entry = {1'b0, A_NONE, `FL_RESET};
        `OP_ADD_SECTOR: seq_entry = {1'b0, A_USER, `FL_SECTOR_ERASE};
        `OP_BYPASS_PROGRAM: seq_entry = (idx == 3'h0) ? {1'b0, A_NONE, `FL_PROGRAM} : {1'b1, A_USER, `FL_ZERO};
        `OP_BYPASS_EXIT: seq_entry = (idx == 3'h0) ? {1'b0, A_NONE, `FL_BYPASS_RESET1} : {1'b0, A_NONE, `FL_ZERO};
        default: begin
          // every other operation opens with the unlock pair
          case (idx)
            3'h0: seq_entry = {1'b0, A_UNLOCK1, `FL_UNLOCK1};
            3'h1: seq_entry = {1'b0, A_UNLOCK2, `FL_UNLOCK2};
            3'h2: begin
              case (code)
                `OP_PROGRAM: seq_entry = {1'b0, A_UNLOCK1, `FL_PROGRAM};
                `OP_ENTER_SECURED: seq_entry = {1'b0, A_UNLOCK1, `FL_ENTER_SECURED};
                `OP_EXIT_SECURED: seq_entry = {1'b0, A_UNLOCK1, `FL_EXIT_SECURED};
                `OP_BYPASS_ENTER: seq_entry = {1'b0, A_UNLOCK1, `FL_BYPASS};
                default: seq_entry = {1'b0, A_UNLOCK1, `FL_ERASE_SETUP};
              endcase
            end
            3'h3: begin
              if (code == `OP_PROGRAM) begin
                seq_entry = {1'b1, A_USER, `FL_ZERO};
              end else if (code == `OP_EXIT_SECURED) begin
                seq_entry = {1'b0, A_NONE, `FL_ZERO};
              end else begin
                seq_entry = {1'b0, A_UNLOCK1, `FL_UNLOCK1};
              end
            end
            3'h4: seq_entry = {1'b0, A_UNLOCK2, `FL_UNLOCK2};
            default: begin
              if (code == `OP_CHIP_ERASE) begin
                seq_entry = {1'b0, A_UNLOCK1, `FL_CHIP_ERASE};
              end else begin
                seq_entry = {1'b0, A_USER, `FL_SECTOR_ERASE};
              end
            end
          endcase
        end
      endcase
    end
  endfunction

  // whether an operation may start now; the host never writes out of order
  function cmd_allowed;
    input [3:0] code;
    input in_bypass;
    input [2:0] cur_state;
    begin
      if (cur_state == S_WINDOW) begin
        cmd_allowed = (code == `OP_ADD_SECTOR);
      end else if (cur_state != S_IDLE) begin
        cmd_allowed = 1'b0;
      end else if (in_bypass) begin
        cmd_allowed = (code == `OP_BYPASS_PROGRAM) || (code == `OP_BYPASS_EXIT) || (code == `OP_READ);
      end else begin
        cmd_allowed = (code != `OP_BYPASS_PROGRAM) && (code != `OP_BYPASS_EXIT) && (code != `OP_ADD_SECTOR) &&
                      (code <= `OP_BYPASS_EXIT);
      end
    end
  endfunction

  assign entry = seq_entry(op, step);
  assign entry_addr = (entry[9:8] == A_USER) ? user_addr :
                      (entry[9:8] == A_UNLOCK1) ? (cfg[`CFG_BYTE_MODE] ? `FL_ADDR1_BYTE : `FL_ADDR1_WORD) :
                      (entry[9:8] == A_UNLOCK2) ? (cfg[`CFG_BYTE_MODE] ? `FL_ADDR2_BYTE : `FL_ADDR2_WORD) :
                      22'h000000;
  // in byte mode only the low lane carries data
  assign entry_data = entry[10] ? (cfg[`CFG_BYTE_MODE] ? {8'h00, user_data[7:0]} : user_data) : {8'h00, entry[7:0]};

  assign pready = 1'b1;
  assign pslverr = psel && penable && (paddr != `REG_CMD) && (paddr != `REG_CONFIG) && (paddr != `REG_ADDR) &&
                   (paddr != `REG_DATA) && (paddr != `REG_STATUS);

  wire apb_write = psel && penable && pwrite;
  wire cmd_write = apb_write && (paddr == `REG_CMD);
  wire cmd_ok = cmd_allowed(pwdata[3:0], bypass, state) && !cfg[`CFG_HW_RESET];
  wire last_step = (step == seq_len(op) - 3'h1);

  // three-flop path for ready/busy, acted on once the last two agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb1 <= 1'b1;
      rb2 <= 1'b1;
      rb3 <= 1'b1;
      rb_stable <= 1'b1;
    end else begin
      rb1 <= ready_busy_n;
      rb2 <= rb1;
      rb3 <= rb2;
      if (rb2 == rb3) begin
        rb_stable <= rb3;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `REG_CONFIG: prdata <= {29'h00000000, cfg};
        `REG_ADDR: prdata <= {10'h000, user_addr};
        `REG_DATA: prdata <= {16'h0000, user_data};
        `REG_STATUS: prdata <= {read_data, 9'h000, state == S_WINDOW, rb_stable, secured, bypass,
                                error_flag, done_flag, state != S_IDLE};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= `CFG_RESET_VALUE;
      user_addr <= 22'h000000;
      user_data <= 16'h0000;
      flash_byte_n <= 1'b1;
      flash_reset_n <= 1'b1;
      accel_high_voltage <= 1'b0;
    end else begin
      if (apb_write && paddr == `REG_CONFIG) begin
        cfg <= pwdata[2:0];
      end
      if (apb_write && paddr == `REG_ADDR) begin
        user_addr <= pwdata[21:0];
      end
      if (apb_write && paddr == `REG_DATA) begin
        user_data <= pwdata[15:0];
      end
      flash_byte_n <= ~cfg[`CFG_BYTE_MODE];
      flash_reset_n <= ~cfg[`CFG_HW_RESET];
      // high voltage only while bypass programming is possible
      accel_high_voltage <= cfg[`CFG_ACCEL] && !cfg[`CFG_HW_RESET];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      op <= `OP_READ;
      step <= 3'h0;
      cnt <= 16'h0000;
      cyc_start <= 1'b0;
      read_data <= 16'h0000;
      done_flag <= 1'b0;
      error_flag <= 1'b0;
      bypass <= 1'b0;
      secured <= 1'b0;
    end else begin
      cyc_start <= 1'b0;
      // software clears by writing ones; a same-cycle set still wins
      if (apb_write && paddr == `REG_STATUS) begin
        if (pwdata[`ST_DONE]) begin
          done_flag <= 1'b0;
        end
        if (pwdata[`ST_ERROR]) begin
          error_flag <= 1'b0;
        end
      end
      if (cmd_write && !cmd_ok) begin
        error_flag <= 1'b1;
      end
      if (cfg[`CFG_HW_RESET]) begin
        // the device drops back to read mode, so our view of it does too
        state <= S_IDLE;
        step <= 3'h0;
        bypass <= 1'b0;
        secured <= 1'b0;
      end else begin
        if (cfg[`CFG_ACCEL]) begin
          bypass <= 1'b1;
        end
        case (state)
          S_IDLE: begin
            if (cmd_write && cmd_ok) begin
              op <= pwdata[3:0];
              step <= 3'h0;
              state <= S_ISSUE;
            end
          end
          S_ISSUE: begin
            cyc_start <= 1'b1;
            state <= S_WAIT;
          end
          S_WAIT: begin
            if (cyc_done) begin
              cnt <= 16'h0000;
              if (!last_step) begin
                step <= step + 3'h1;
                state <= S_ISSUE;
              end else begin
                state <= S_IDLE;
                done_flag <= 1'b1;
                case (op)
                  `OP_READ: read_data <= cyc_rdata;
                  `OP_ENTER_SECURED: secured <= 1'b1;
                  `OP_EXIT_SECURED: secured <= 1'b0;
                  `OP_BYPASS_ENTER: bypass <= 1'b1;
                  `OP_BYPASS_EXIT: bypass <= cfg[`CFG_ACCEL];
                  `OP_PROGRAM, `OP_CHIP_ERASE, `OP_BYPASS_PROGRAM: begin
                    done_flag <= 1'b0;
                    state <= S_SETTLE;
                  end
                  `OP_SECTOR_ERASE, `OP_ADD_SECTOR: begin
                    done_flag <= 1'b0;
                    state <= S_WINDOW;
                  end
                  default: state <= S_IDLE;
                endcase
              end
            end
          end
          S_WINDOW: begin
            // each added sector restarts the gap so writes stay under the window
            if (cmd_write && cmd_ok) begin
              op <= `OP_ADD_SECTOR;
              step <= 3'h0;
              state <= S_ISSUE;
            end else if (cnt >= WINDOW_CYC - 16'h0001) begin
              cnt <= 16'h0000;
              state <= S_SETTLE;
            end else begin
              cnt <= cnt + 16'h0001;
            end
          end
          S_SETTLE: begin
            // give the device time to pull ready/busy low before polling
            if (cnt >= `BUSY_SETTLE_CYC - 1) begin
              state <= S_POLL;
            end else begin
              cnt <= cnt + 16'h0001;
            end
          end
          S_POLL: begin
            if (rb_stable) begin
              done_flag <= 1'b1;
              state <= S_IDLE;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // zeros written over ones are left to the device; no read-modify-write here
  flash_bus_cycle u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .start(cyc_start),
    .write(op != `OP_READ),
    .addr(entry_addr),
    .wdata(entry_data),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n)
  );
endmodule

// file: hdl/flash_seq_defines.vh
// constants shared by the flash sequencer host: register map, fields, commands, timing
`ifndef FLASH_SEQ_DEFINES_VH
`define FLASH_SEQ_DEFINES_VH

// register byte offsets
`define REG_CMD 8'h00
`define REG_CONFIG 8'h04
`define REG_ADDR 8'h08
`define REG_DATA 8'h0C
`define REG_STATUS 8'h10

// config fields
`define CFG_BYTE_MODE 0
`define CFG_ACCEL 1
`define CFG_HW_RESET 2
`define CFG_RESET_VALUE 3'h0

// status fields
`define ST_BUSY 0
`define ST_DONE 1
`define ST_ERROR 2
`define ST_BYPASS 3
`define ST_SECURED 4
`define ST_READY_PIN 5
`define ST_WINDOW 6
`define ST_RDATA_LSB 16

// operation codes written to the command register
`define OP_READ 4'h0
`define OP_RESET 4'h1
`define OP_PROGRAM 4'h2
`define OP_CHIP_ERASE 4'h3
`define OP_SECTOR_ERASE 4'h4
`define OP_ADD_SECTOR 4'h5
`define OP_ENTER_SECURED 4'h6
`define OP_EXIT_SECURED 4'h7
`define OP_BYPASS_ENTER 4'h8
`define OP_BYPASS_PROGRAM 4'h9
`define OP_BYPASS_EXIT 4'hA

// flash command bytes
`define FL_UNLOCK1 8'hAA
`define FL_UNLOCK2 8'h55
`define FL_RESET 8'hF0
`define FL_PROGRAM 8'hA0
`define FL_ERASE_SETUP 8'h80
`define FL_CHIP_ERASE 8'h10
`define FL_SECTOR_ERASE 8'h30
`define FL_ENTER_SECURED 8'h88
`define FL_EXIT_SECURED 8'h90
`define FL_BYPASS 8'h20
`define FL_BYPASS_RESET1 8'h90
`define FL_ZERO 8'h00

// unlock addresses, word and byte mode
`define FL_ADDR1_WORD 22'h000555
`define FL_ADDR2_WORD 22'h0002AA
`define FL_ADDR1_BYTE 22'h000AAA
`define FL_ADDR2_BYTE 22'h000555

// timing
`define PCLK_NS 10
`define ADDR_SETUP_NS 20
`define WE_PULSE_NS 50
`define WE_HOLD_NS 30
`define READ_ACCESS_NS 90
`define ADDR_SETUP_CYC (((`ADDR_SETUP_NS) + (`PCLK_NS) - 1) / (`PCLK_NS))
`define WE_PULSE_CYC (((`WE_PULSE_NS) + (`PCLK_NS) - 1) / (`PCLK_NS))
`define WE_HOLD_CYC (((`WE_HOLD_NS) + (`PCLK_NS) - 1) / (`PCLK_NS))
`define READ_ACCESS_CYC (((`READ_ACCESS_NS) + (`PCLK_NS) - 1) / (`PCLK_NS))
`define ERASE_WINDOW_NS 50000
`define ERASE_WINDOW_CYC ((`ERASE_WINDOW_NS) / (`PCLK_NS))
`define BUSY_SETTLE_NS 200
`define BUSY_SETTLE_CYC (((`BUSY_SETTLE_NS) + (`PCLK_NS) - 1) / (`PCLK_NS))

`endif

// file: hdl/flash_bus_cycle.v
// one asynchronous flash bus cycle, write or read, with timed strobes
`timescale 1ns/1ps
`include "flash_seq_defines.vh"

module flash_bus_cycle (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // request from the sequencer
  input wire start,
  input wire write,
  input wire [21:0] addr,
  input wire [15:0] wdata,
  output reg done,
  output reg [15:0] rdata,
  // flash pins
  output reg [21:0] flash_addr,
  output reg [15:0] flash_dq_out,
  output reg flash_dq_oe,
  input wire [15:0] flash_dq_in,
  output reg flash_ce_n,
  output reg flash_we_n,
  output reg flash_oe_n
);
  localparam E_IDLE = 3'h0;
  localparam E_SETUP = 3'h1;
  localparam E_STROBE = 3'h2;
  localparam E_HOLD = 3'h3;
  localparam E_SAMPLE = 3'h4;

  reg [2:0] state;
  reg [3:0] cnt;
  reg is_write;
  reg [15:0] dq1;
  reg [15:0] dq2;
  reg [15:0] dq3;

  // three-flop path for the data pins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq1 <= 16'h0000;
      dq2 <= 16'h0000;
      dq3 <= 16'h0000;
    end else begin
      dq1 <= flash_dq_in;
      dq2 <= dq1;
      dq3 <= dq2;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= E_IDLE;
      cnt <= 4'h0;
      is_write <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      flash_addr <= 22'h000000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state)
        E_IDLE: begin
          if (start) begin
            is_write <= write;
            flash_addr <= addr;
            flash_dq_out <= wdata;
            flash_dq_oe <= write;
            flash_ce_n <= 1'b0;
            cnt <= 4'h0;
            state <= E_SETUP;
          end
        end
        E_SETUP: begin
          // address is stable before the later falling strobe
          if (cnt == `ADDR_SETUP_CYC - 1) begin
            cnt <= 4'h0;
            flash_we_n <= ~is_write;
            flash_oe_n <= is_write;
            state <= E_STROBE;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        E_STROBE: begin
          if (is_write && cnt == `WE_PULSE_CYC - 1) begin
            // write strobe rises first, so it latches the data
            flash_we_n <= 1'b1;
            cnt <= 4'h0;
            state <= E_HOLD;
          end else if (!is_write && cnt == `READ_ACCESS_CYC + 2) begin
            state <= E_SAMPLE;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        E_HOLD: begin
          if (cnt == `WE_HOLD_CYC - 1) begin
            flash_ce_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            done <= 1'b1;
            state <= E_IDLE;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        E_SAMPLE: begin
          // take the data only once two synchronised samples agree
          if (dq2 == dq3) begin
            rdata <= dq3;
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            done <= 1'b1;
            state <= E_IDLE;
          end
        end
        default: begin
          state <= E_IDLE;
        end
      endcase
    end
  end
endmodule

// file: hdl/flash_seq_host_unused_guard.v
// holds no logic: the sequencer lives in flash_seq_host.v and flash_bus_cycle.v

// file: test/flash_seq_host_asserts.sv
// concurrent checks on the apb and flash pins of the sequencer host
`timescale 1ns/1ps
`include "flash_seq_defines.vh"
module flash_seq_host_asserts #(
  parameter [15:0] WINDOW_CYC = 16'd5000
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // flash pins
  input wire [21:0] flash_addr,
  input wire [15:0] flash_dq_out,
  input wire flash_dq_oe,
  input wire [15:0] flash_dq_in,
  input wire flash_ce_n,
  input wire flash_we_n,
  input wire flash_oe_n,
  input wire flash_byte_n,
  input wire flash_reset_n,
  input wire accel_high_voltage,
  input wire ready_busy_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire wr_cfg = acc && pwrite && paddr == `REG_CONFIG;
  // pin flops follow the config flops, so a written value reaches the pins two edges after the write
  wire accel_req = pwdata[1] && !pwdata[2];
  wire mapped = paddr == `REG_CMD || paddr == `REG_CONFIG || paddr == `REG_ADDR ||
    paddr == `REG_DATA || paddr == `REG_STATUS;
  // the strobe must stay low long enough for the device to take the data
  sequence we_low;
    !flash_we_n [*5] ##1 flash_we_n;
  endsequence
  zero_wait_a: assert property (acc |-> pready) else $error("access phase without ready");
  bad_addr_a: assert property (acc && !mapped |-> pslverr) else $error("unmapped access not flagged");
  good_addr_a: assert property (acc && mapped |-> !pslverr) else $error("mapped access flagged");
  cmd_reads_a: assert property (psel && !penable && !pwrite && paddr == `REG_CMD |=> prdata == 32'h0)
    else $error("command register read not zero");
  byte_pin_a: assert property (wr_cfg |-> ##2 flash_byte_n == !$past(pwdata[0], 2))
    else $error("byte pin wrong");
  reset_pin_a: assert property (wr_cfg |-> ##2 flash_reset_n == !$past(pwdata[2], 2))
    else $error("reset pin wrong");
  accel_pin_a: assert property (wr_cfg |-> ##2 accel_high_voltage == $past(accel_req, 2))
    else $error("accel pin wrong");
  we_pulse_a: assert property ($fell(flash_we_n) |-> we_low) else $error("write strobe width wrong");
  we_frame_a: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe && flash_oe_n)
    else $error("write strobe outside frame");
  ce_lead_a: assert property ($fell(flash_we_n) |-> $past(flash_ce_n) == 1'b0) else $error("no select lead");
  latch_hold_a: assert property (!flash_we_n |=> flash_we_n || ($stable(flash_addr) && $stable(flash_dq_out)))
    else $error("pins moved under strobe");
endmodule

bind flash_seq_host flash_seq_host_asserts #(.WINDOW_CYC(WINDOW_CYC)) i_flash_seq_host_asserts (.*);

// file: test/flash_device_model.sv
// behavioural flash device: logs bus writes, programs, erases, reports busy
`timescale 1ns/1ps
module flash_device_model (
  input wire pclk,
  input wire [21:0] flash_addr,
  input wire [15:0] flash_dq_out,
  input wire flash_dq_oe,
  output logic [15:0] flash_dq_in,
  input wire flash_ce_n,
  input wire flash_we_n,
  input wire flash_oe_n,
  input wire flash_byte_n,
  input wire flash_reset_n,
  input wire accel_high_voltage,
  output logic ready_busy_n
);
  logic [21:0] la [0:63];
  logic [15:0] ld [0:63];
  logic [15:0] mem [0:255];
  logic [21:0] lat;
  logic [15:0] last = 16'h0000;
  int n = 0;
  int busy = 0;
  logic arm = 0;
  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  // ce falls first, so the strobe fall is the later falling edge
  always @(negedge flash_we_n) if (!flash_ce_n) lat = flash_addr;
  always @(posedge flash_we_n) begin
    if (!flash_ce_n && flash_reset_n) begin
      la[n] = lat;
      ld[n] = flash_dq_out;
      n++;
      // commands during an embedded operation are dropped
      if (busy == 0) begin
        if (arm) begin
          mem[lat[7:0]] &= flash_byte_n ? flash_dq_out : {8'hFF, flash_dq_out[7:0]};
          busy = 30;
          arm = 0;
        end else if (flash_dq_out[7:0] == 8'hA0) arm = 1;
        else if (flash_dq_out[7:0] == 8'h10 || flash_dq_out[7:0] == 8'h30) begin
          foreach (mem[i]) mem[i] = 16'hFFFF;
          busy = 60;
        end else arm = 0;
      end
    end
  end
  always @(posedge pclk) begin
    if (!flash_reset_n) begin
      busy = 0;
      arm = 0;
    end else if (busy > 0) busy--;
    last <= flash_dq_in;
  end
  assign ready_busy_n = (busy == 0);
  // a released bus shows the inverse of its last value, never a stale copy
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? (busy != 0 ? 16'h0000 : mem[flash_addr[7:0]]) : ~last;
endmodule

// file: test/tb.sv
// self-checking testbench for the flash sequencer host
`timescale 1ns/1ps
`include "flash_seq_defines.vh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, err_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, dq_oe, ce_n, we_n, oe_n, byte_n, rst_n, accel, rb_n;
  wire [21:0] fa;
  wire [15:0] dqo, dqi;
  int error_cnt = 0;
  int total_checks = 0;
  int p;
  flash_seq_host #(.WINDOW_CYC(16'd50)) i_flash_seq_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_addr(fa), .flash_dq_out(dqo), .flash_dq_oe(dq_oe), .flash_dq_in(dqi),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_byte_n(byte_n), .flash_reset_n(rst_n),
    .accel_high_voltage(accel), .ready_busy_n(rb_n));
  flash_device_model i_flash_device_model (.pclk(pclk), .flash_addr(fa), .flash_dq_out(dqo), .flash_dq_oe(dq_oe),
    .flash_dq_in(dqi), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_byte_n(byte_n),
    .flash_reset_n(rst_n), .accel_high_voltage(accel), .ready_busy_n(rb_n));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      chk("pready", 1, 0);
      give_verdict;
    end
    rd = prdata;
    err_seen = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task poll(input int b, input logic v);
    int k;
    for (k = 0; k < 3000; k++) begin
      apb(0, `REG_STATUS, 0);
      if (rd[b] === v) break;
    end
    if (k == 3000) begin
      chk("poll", 0, 1);
      give_verdict;
    end
  endtask
  task cmd(input logic [3:0] op);
    p = i_flash_device_model.n;
    apb(1, `REG_CMD, {28'h0, op});
    poll(`ST_BUSY, 0);
  endtask
  task ex(input logic [21:0] a, input logic [15:0] d);
    chk("bus addr", a, i_flash_device_model.la[p]);
    chk("bus data", d, i_flash_device_model.ld[p]);
    p++;
  endtask
  task st(input int b, input logic v, input string nm);
    apb(0, `REG_STATUS, 0);
    chk(nm, v, rd[b]);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, `REG_STATUS, 0);
    chk("status", 32'h1 << `ST_READY_PIN, rd);
    apb(0, `REG_CMD, 0);
    chk("cmd reads", 0, rd);
    apb(0, `REG_CONFIG, 0);
    chk("config", 0, rd);
    apb(1, `REG_ADDR, 5);
    apb(1, `REG_DATA, 16'h1234);
    cmd(`OP_PROGRAM);
    ex(22'h555, 16'hAA); ex(22'h2AA, 16'h55); ex(22'h555, 16'hA0); ex(22'h5, 16'h1234);
    st(`ST_DONE, 1, "done");
    apb(1, `REG_STATUS, 32'h6);
    apb(1, `REG_DATA, 16'hFFFF);
    cmd(`OP_PROGRAM);
    cmd(`OP_READ);
    chk("read back", 16'h1234, rd[31:16]);
    cmd(`OP_CHIP_ERASE);
    ex(22'h555, 16'hAA); ex(22'h2AA, 16'h55); ex(22'h555, 16'h80);
    ex(22'h555, 16'hAA); ex(22'h2AA, 16'h55); ex(22'h555, 16'h10);
    cmd(`OP_READ);
    chk("erased", 16'hFFFF, rd[31:16]);
    p = i_flash_device_model.n;
    apb(1, `REG_ADDR, 22'h40);
    apb(1, `REG_CMD, `OP_SECTOR_ERASE);
    poll(`ST_WINDOW, 1);
    apb(1, `REG_ADDR, 22'h80);
    apb(1, `REG_CMD, `OP_ADD_SECTOR);
    apb(1, `REG_CMD, `OP_PROGRAM);
    st(`ST_ERROR, 1, "window refuse");
    poll(`ST_BUSY, 0);
    ex(22'h555, 16'hAA); ex(22'h2AA, 16'h55); ex(22'h555, 16'h80);
    ex(22'h555, 16'hAA); ex(22'h2AA, 16'h55); ex(22'h40, 16'h30); ex(22'h80, 16'h30);
    chk("bus count", p, i_flash_device_model.n);
    apb(1, `REG_STATUS, 32'h6);
    cmd(`OP_BYPASS_ENTER);
    ex(22'h555, 16'hAA); ex(22'h2AA, 16'h55); ex(22'h555, 16'h20);
    st(`ST_BYPASS, 1, "bypass");
    apb(1, `REG_ADDR, 9);
    apb(1, `REG_DATA, 16'h0F0F);
    cmd(`OP_BYPASS_PROGRAM);
    ex(22'h0, 16'hA0); ex(22'h9, 16'h0F0F);
    apb(1, `REG_CMD, `OP_PROGRAM);
    st(`ST_ERROR, 1, "bypass refuse");
    apb(1, `REG_STATUS, 32'h6);
    cmd(`OP_BYPASS_EXIT);
    ex(22'h0, 16'h90); ex(22'h0, 16'h00);
    st(`ST_BYPASS, 0, "bypass off");
    cmd(`OP_ENTER_SECURED);
    ex(22'h555, 16'hAA); ex(22'h2AA, 16'h55); ex(22'h555, 16'h88);
    st(`ST_SECURED, 1, "secured");
    cmd(`OP_EXIT_SECURED);
    ex(22'h555, 16'hAA); ex(22'h2AA, 16'h55); ex(22'h555, 16'h90); ex(22'h0, 16'h00);
    st(`ST_SECURED, 0, "secured off");
    apb(1, `REG_CONFIG, 1);
    apb(1, `REG_ADDR, 6);
    cmd(`OP_PROGRAM);
    chk("byte pin", 0, byte_n);
    ex(22'hAAA, 16'hAA); ex(22'h555, 16'h55); ex(22'hAAA, 16'hA0);
    apb(1, `REG_CONFIG, 2);
    st(`ST_BYPASS, 1, "accel bypass");
    chk("accel pin", 1, accel);
    apb(1, `REG_CONFIG, 4);
    apb(1, `REG_CMD, `OP_PROGRAM);
    st(`ST_ERROR, 1, "reset refuse");
    chk("reset pin", 0, rst_n);
    chk("accel off", 0, accel);
    apb(1, `REG_CONFIG, 0);
    apb(0, 8'h20, 0);
    chk("slverr", 1, err_seen);
    give_verdict;
  end
endmodule
